// [pkg/ppm_defines.vh]
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPM_OFS_CONFIG   8'h00
`define PPM_OFS_ONESHOT  8'h04
`define PPM_OFS_PEAKCFG  8'h08
`define PPM_OFS_STATUS   8'h0C
`define PPM_OFS_IRQ_STAT 8'h10
`define PPM_OFS_IRQ_MASK 8'h14
`define PPM_OFS_RESULTS  8'h18
`define PPM_OFS_POWER    8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PPM_CFG_MODE_LO   0
`define PPM_CFG_MODE_HI   1
`define PPM_CFG_ALERT_CMP 2
`define PPM_PK_THR_LO     0
`define PPM_PK_THR_HI     3
`define PPM_PK_DUR_LO     4
`define PPM_PK_DUR_HI     7
`define PPM_IRQ_PEAK      0
`define PPM_IRQ_POWER     1
`define PPM_IRQ_ONESHOT   2

// ----------------------------------------
// Modes and reset values
// ----------------------------------------
`define PPM_MODE_ACTIVE  2'h0
`define PPM_MODE_CURRENT 2'h1
`define PPM_MODE_TEMP    2'h2
`define PPM_MODE_STANDBY 2'h3
`define PPM_RST_CONFIG   3'h0
`define PPM_RST_MASK     3'h7

// ----------------------------------------
// Arithmetic and timing
// ----------------------------------------
`define PPM_PWR_SHIFT    5
`define PPM_PWR_MAX      16'hFFFF
`define PPM_THR_BASE_MV  10
`define PPM_THR_STEP_MV  5
`define PPM_SENSE_FS_MV  80
`define PPM_SENSE_FS_CODE 1023
`define PPM_CLK_HZ       40000000
`define PPM_T_TICK_US    1000
`define PPM_T_FILTER_NS  1000
`define PPM_TICK_CYC     ((`PPM_CLK_HZ / 1000000) * `PPM_T_TICK_US)
`define PPM_FILTER_CYC   ((`PPM_T_FILTER_NS * (`PPM_CLK_HZ / 1000000) + 999) / 1000)

`endif

// [rtl/ppm_core.v]
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`include "ppm_defines.vh"
`default_nettype none

module ppm_core #(
    parameter TICK_CYC   = `PPM_TICK_CYC,
    parameter FILTER_CYC = `PPM_FILTER_CYC
) (
    // Clock, reset, enable
    input  wire        CLK,
    input  wire        RESET,
    input  wire        CE,
    // AXI4-Lite slave
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    // Converter results
    input  wire [10:0] SENSE_RESULT,
    input  wire        SENSE_DONE,
    input  wire [10:0] SOURCE_RESULT,
    input  wire        SOURCE_DONE,
    input  wire        TEMP_DONE,
    // Instantaneous current for the peak path
    input  wire [10:0] PEAK_SAMPLE,
    // Power-up selection straps
    input  wire [3:0]  THRESHOLD_SELECT_PIN,
    input  wire [3:0]  DURATION_SELECT_PIN,
    // Conversion control
    output reg         TEMP_CONV_EN,
    output reg         VOLT_CONV_EN,
    output reg         LIMIT_CHK_EN,
    // Results and alarms
    output reg  [15:0] POWER_RATIO,
    output reg         CRITICAL_ALARM_PIN_N,
    output reg         ALERT_PIN_N,
    output reg         IRQ
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [12:0] dur_ms;
        input [3:0] sel;
        begin
            case (sel)
                4'h0: dur_ms = 13'd1;
                4'h1: dur_ms = 13'd5;
                4'h2: dur_ms = 13'd26;
                4'h3: dur_ms = 13'd51;
                4'h4: dur_ms = 13'd77;
                4'h5: dur_ms = 13'd102;
                4'h6: dur_ms = 13'd128;
                4'h7: dur_ms = 13'd256;
                4'h8: dur_ms = 13'd384;
                4'h9: dur_ms = 13'd512;
                4'hA: dur_ms = 13'd768;
                4'hB: dur_ms = 13'd1024;
                4'hC: dur_ms = 13'd1536;
                4'hD: dur_ms = 13'd2048;
                4'hE: dur_ms = 13'd3072;
                default: dur_ms = 13'd4096;
            endcase
        end
    endfunction

    function [10:0] mag11;
        input [10:0] v;
        begin
            mag11 = v[10] ? (~v + 11'h001) : v;
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    localparam PK_IDLE = 2'd0;
    localparam PK_TIME = 2'd1;
    localparam PK_HIT  = 2'd2;

    reg  [2:0]  config_r;
    reg  [3:0]  thr_sel_r;
    reg  [3:0]  duration_select_pin_r;
    reg         strap_done_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_mask_r;
    reg         os_temp_r;
    reg         os_volt_r;
    reg         os_sns_r;
    reg         os_src_r;
    reg  [10:0] sense_r;
    reg  [10:0] source_r;
    reg         recalc_r;
    reg  [1:0]  pk_state_r;
    reg  [31:0] tick_cnt_r;
    reg  [12:0] ms_cnt_r;
    reg  [31:0] flt_cnt_r;

    wire [1:0]  mode      = config_r[`PPM_CFG_MODE_HI:`PPM_CFG_MODE_LO];
    wire        alert_cmp = config_r[`PPM_CFG_ALERT_CMP];

    // ----------------------------------------
    // AXI4-Lite handshakes
    // ----------------------------------------
    wire wr_go = S_AXI_AWREADY;
    wire rd_go = S_AXI_ARREADY;
    wire wr_map = (S_AXI_AWADDR == `PPM_OFS_CONFIG) || (S_AXI_AWADDR == `PPM_OFS_ONESHOT) ||
                  (S_AXI_AWADDR == `PPM_OFS_PEAKCFG) || (S_AXI_AWADDR == `PPM_OFS_IRQ_MASK);
    wire wr_cfg  = wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == `PPM_OFS_CONFIG);
    wire wr_os   = wr_go && (S_AXI_AWADDR == `PPM_OFS_ONESHOT);
    wire wr_pk   = wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == `PPM_OFS_PEAKCFG);
    wire wr_msk  = wr_go && S_AXI_WSTRB[0] && (S_AXI_AWADDR == `PPM_OFS_IRQ_MASK);
    wire rd_irq  = rd_go && (S_AXI_ARADDR == `PPM_OFS_IRQ_STAT);

    // ----------------------------------------
    // Mode sequencer
    // ----------------------------------------
    wire mode_temp = (mode == `PPM_MODE_ACTIVE) || (mode == `PPM_MODE_TEMP);
    wire mode_volt = (mode == `PPM_MODE_ACTIVE) || (mode == `PPM_MODE_CURRENT);
    wire temp_on   = mode_temp || os_temp_r;
    wire volt_on   = mode_volt || os_volt_r;
    wire take_sns  = SENSE_DONE && volt_on;
    wire take_src  = SOURCE_DONE && volt_on;
    wire os_sns_nxt = os_sns_r || take_sns;
    wire os_src_nxt = os_src_r || take_src;
    wire os_end = (os_temp_r && TEMP_DONE && !(os_volt_r && !(os_sns_nxt && os_src_nxt))) ||
                  (!os_temp_r && os_volt_r && os_sns_nxt && os_src_nxt);

    // ----------------------------------------
    // Peak detector
    // ----------------------------------------
    wire [10:0] pk_mag = mag11(PEAK_SAMPLE);
    wire [6:0]  thr_mv = 7'd`PPM_THR_BASE_MV + 7'd`PPM_THR_STEP_MV * {3'h0, thr_sel_r};
    wire [17:0] thr_prod = {11'h000, thr_mv} * 18'd`PPM_SENSE_FS_CODE;
    wire [17:0] thr_quo  = thr_prod / 18'd`PPM_SENSE_FS_MV;
    wire [10:0] thr_code = thr_quo[10:0];
    wire        above = pk_mag > thr_code;
    wire        tick  = (tick_cnt_r == TICK_CYC - 1);
    wire [12:0] dur_lim = dur_ms(duration_select_pin_r);
    wire        filt_out = (flt_cnt_r >= FILTER_CYC);

    // ----------------------------------------
    // Power product
    // ----------------------------------------
    wire [21:0] pwr_prod = {11'h000, mag11(sense_r)} * {11'h000, source_r};
    wire [16:0] pwr_sh   = pwr_prod[21:`PPM_PWR_SHIFT];
    wire [15:0] pwr_sat  = pwr_sh[16] ? `PPM_PWR_MAX : pwr_sh[15:0];

    // ----------------------------------------
    // Configuration, status and bus
    // ----------------------------------------
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            config_r      <= `PPM_RST_CONFIG;
            thr_sel_r     <= 4'h0;
            duration_select_pin_r     <= 4'h0;
            strap_done_r  <= 1'b0;
            irq_mask_r    <= `PPM_RST_MASK;
            irq_stat_r    <= 3'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'h0;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RRESP   <= 2'h0;
            S_AXI_RDATA   <= 32'h0000_0000;
        end else if (CE) begin
            // Straps are caught once, on the first enabled edge after reset
            if (!strap_done_r) begin
                strap_done_r <= 1'b1;
                thr_sel_r    <= THRESHOLD_SELECT_PIN;
                duration_select_pin_r    <= DURATION_SELECT_PIN;
            end else if (wr_pk) begin
                thr_sel_r    <= S_AXI_WDATA[`PPM_PK_THR_HI:`PPM_PK_THR_LO];
                duration_select_pin_r    <= S_AXI_WDATA[`PPM_PK_DUR_HI:`PPM_PK_DUR_LO];
            end
            if (wr_cfg)
                config_r <= S_AXI_WDATA[2:0];
            if (wr_msk)
                irq_mask_r <= S_AXI_WDATA[2:0];
            // A new event in the clearing cycle survives the read
            irq_stat_r <= (rd_irq ? 3'h0 : irq_stat_r) |
                          {os_end, recalc_r, (pk_state_r == PK_TIME) && tick && (ms_cnt_r + 13'd1 >= dur_lim)};

            S_AXI_AWREADY <= S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY  <= S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_map ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;

            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
            if (rd_go) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= 2'h0;
                case (S_AXI_ARADDR)
                    `PPM_OFS_CONFIG:   S_AXI_RDATA <= {29'h0, config_r};
                    `PPM_OFS_ONESHOT:  S_AXI_RDATA <= {30'h0, os_volt_r, os_temp_r};
                    `PPM_OFS_PEAKCFG:  S_AXI_RDATA <= {24'h0, duration_select_pin_r, thr_sel_r};
                    `PPM_OFS_STATUS:   S_AXI_RDATA <= {29'h0, pk_state_r == PK_TIME, LIMIT_CHK_EN,
                                                       pk_state_r == PK_HIT};
                    `PPM_OFS_IRQ_STAT: S_AXI_RDATA <= {29'h0, irq_stat_r};
                    `PPM_OFS_IRQ_MASK: S_AXI_RDATA <= {29'h0, irq_mask_r};
                    `PPM_OFS_RESULTS:  S_AXI_RDATA <= {5'h0, source_r, 5'h0, sense_r};
                    `PPM_OFS_POWER:    S_AXI_RDATA <= {16'h0, POWER_RATIO};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'h2;
                    end
                endcase
            end else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // ----------------------------------------
    // One-shot and results
    // ----------------------------------------
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            os_temp_r    <= 1'b0;
            os_volt_r    <= 1'b0;
            os_sns_r     <= 1'b0;
            os_src_r     <= 1'b0;
            sense_r      <= 11'h000;
            source_r     <= 11'h000;
            recalc_r     <= 1'b0;
            POWER_RATIO  <= 16'h0000;
            TEMP_CONV_EN <= 1'b0;
            VOLT_CONV_EN <= 1'b0;
            LIMIT_CHK_EN <= 1'b0;
        end else if (CE) begin
            if (wr_os && !(os_temp_r || os_volt_r)) begin
                case (mode)
                    `PPM_MODE_CURRENT: os_temp_r <= 1'b1;
                    `PPM_MODE_TEMP:    os_volt_r <= 1'b1;
                    `PPM_MODE_STANDBY: begin
                        os_temp_r <= 1'b1;
                        os_volt_r <= 1'b1;
                    end
                    default: ;
                endcase
                os_sns_r <= 1'b0;
                os_src_r <= 1'b0;
            end else begin
                // Each pending channel ends on its own result; standby returns when all are in
                if (os_temp_r && TEMP_DONE)
                    os_temp_r <= 1'b0;
                if (os_volt_r) begin
                    os_sns_r <= os_sns_nxt;
                    os_src_r <= os_src_nxt;
                    if (os_sns_nxt && os_src_nxt) begin
                        os_volt_r <= 1'b0;
                        os_sns_r  <= 1'b0;
                        os_src_r  <= 1'b0;
                    end
                end
            end
            if (take_sns)
                sense_r <= SENSE_RESULT;
            if (take_src)
                source_r <= SOURCE_RESULT;
            recalc_r <= take_sns || take_src;
            if (recalc_r)
                POWER_RATIO <= pwr_sat;
            TEMP_CONV_EN <= temp_on;
            VOLT_CONV_EN <= volt_on;
            LIMIT_CHK_EN <= (mode != `PPM_MODE_STANDBY) || os_temp_r || os_volt_r;
        end
    end

    // ----------------------------------------
    // Peak timer and pins
    // ----------------------------------------
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pk_state_r           <= PK_IDLE;
            tick_cnt_r           <= 32'h0000_0000;
            ms_cnt_r             <= 13'h0000;
            flt_cnt_r            <= 32'h0000_0000;
            CRITICAL_ALARM_PIN_N <= 1'b1;
            ALERT_PIN_N          <= 1'b1;
            IRQ                  <= 1'b0;
        end else if (CE) begin
            // Timer and tick restart at each new excursion, so the first tick is a full 1 ms
            if (pk_state_r == PK_IDLE || tick)
                tick_cnt_r <= 32'h0000_0000;
            else
                tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            flt_cnt_r <= (above || pk_state_r == PK_IDLE) ? 32'h0000_0000 : flt_cnt_r + 32'h0000_0001;
            case (pk_state_r)
                PK_IDLE: begin
                    ms_cnt_r <= 13'h0000;
                    if (above)
                        pk_state_r <= PK_TIME;
                end
                PK_TIME: begin
                    if (filt_out)
                        pk_state_r <= PK_IDLE;
                    else if (tick) begin
                        ms_cnt_r <= ms_cnt_r + 13'd1;
                        if (ms_cnt_r + 13'd1 >= dur_lim)
                            pk_state_r <= PK_HIT;
                    end
                end
                PK_HIT: begin
                    if (filt_out)
                        pk_state_r <= PK_IDLE;
                end
                default: pk_state_r <= PK_IDLE;
            endcase
            CRITICAL_ALARM_PIN_N <= !(pk_state_r == PK_HIT);
            ALERT_PIN_N          <= !(alert_cmp && pk_state_r == PK_HIT);
            IRQ                  <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule // ppm_core

`default_nettype wire

// [bench/ppm_conv_model.sv]
`default_nettype none
// ----------------------------------------
// Converter front end feeding the core
// ----------------------------------------
module ppm_conv_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Channel enables and request
    input  wire logic        temp_en,
    input  wire logic        volt_en,
    input  wire logic        go,
    input  wire logic [10:0] sense_in,
    input  wire logic [10:0] source_in,
    // Results
    output logic      [10:0] sense_out,
    output logic             sense_done,
    output logic      [10:0] source_out,
    output logic             source_done,
    output logic             temp_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] tcnt_r;
    // A disabled channel never converts, so requests in standby with no one-shot pending go nowhere
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {sense_done, source_done, temp_done} <= 3'h0;
            tcnt_r <= 3'h0;
        end else begin
            sense_done <= go && volt_en;
            source_done <= sense_done;
            tcnt_r <= temp_en ? tcnt_r + 3'h1 : 3'h0;
            temp_done <= temp_en && (tcnt_r == 3'h7);
        end
    end
    // Result lines are only valid with their strobe; otherwise show junk
    assign sense_out = sense_done ? sense_in : ~sense_in;
    assign source_out = source_done ? source_in : ~source_in;
endmodule // ppm_conv_model
`default_nettype wire

// [bench/ppm_core_chk.sv]
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module ppm_chk #(
    parameter int FILTER_CYC = 3
) (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // Bus
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // Core
    input wire logic        SENSE_DONE,
    input wire logic        SOURCE_DONE,
    input wire logic [10:0] PEAK_SAMPLE,
    input wire logic        TEMP_CONV_EN,
    input wire logic        VOLT_CONV_EN,
    input wire logic        LIMIT_CHK_EN,
    input wire logic [15:0] POWER_RATIO,
    input wire logic        CRITICAL_ALARM_PIN_N,
    input wire logic        ALERT_PIN_N
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] mag;
    logic [3:0]  quiet_r;
    assign mag = PEAK_SAMPLE[10] ? (~PEAK_SAMPLE + 11'h001) : PEAK_SAMPLE;
    // Cycles below the lowest threshold; saturates so long idle stays counted
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            quiet_r <= 4'h0;
        end else if (mag > 11'h07F) begin
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hF) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence wr_resp_s;
        S_AXI_AWREADY && S_AXI_WREADY ##1 S_AXI_BVALID;
    endsequence
    sequence rd_resp_s;
        S_AXI_ARREADY ##1 S_AXI_RVALID;
    endsequence
    quiet_release_a:
        assert property (quiet_r > FILTER_CYC + 3 |-> CRITICAL_ALARM_PIN_N && ALERT_PIN_N) else $error("alarm without peak");
    alert_crit_a:
        assert property (!ALERT_PIN_N |-> !CRITICAL_ALARM_PIN_N) else $error("alert without held peak");
    power_cause_a:
        assert property (!$stable(POWER_RATIO) |-> $past(SENSE_DONE, 2) || $past(SOURCE_DONE, 2))
        else $error("power changed without result");
    standby_idle_a:
        assert property (!LIMIT_CHK_EN |-> !TEMP_CONV_EN && !VOLT_CONV_EN) else $error("conversion while idle");
    write_resp_a:
        assert property (S_AXI_AWREADY |-> wr_resp_s) else $error("write response late");
    read_resp_a:
        assert property (S_AXI_ARREADY |-> rd_resp_s) else $error("read response late");
    b_release_a:
        assert property ($fell(S_AXI_BVALID) |-> $past(S_AXI_BREADY)) else $error("bvalid dropped early");
    r_release_a:
        assert property ($fell(S_AXI_RVALID) |-> $past(S_AXI_RREADY)) else $error("rvalid dropped early");
endmodule // ppm_chk
bind ppm_core ppm_chk #(.FILTER_CYC(FILTER_CYC)) u_ppm_chk (
    .CLK(CLK), .RESET(RESET), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .SENSE_DONE(SENSE_DONE),
    .SOURCE_DONE(SOURCE_DONE), .PEAK_SAMPLE(PEAK_SAMPLE), .TEMP_CONV_EN(TEMP_CONV_EN),
    .VOLT_CONV_EN(VOLT_CONV_EN), .LIMIT_CHK_EN(LIMIT_CHK_EN), .POWER_RATIO(POWER_RATIO),
    .CRITICAL_ALARM_PIN_N(CRITICAL_ALARM_PIN_N), .ALERT_PIN_N(ALERT_PIN_N)
);
`default_nettype wire

// [bench/power_peak_monitor_core_bench.sv]
`include "ppm_defines.vh"
`default_nettype none
module power_peak_monitor_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, ce, go, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sen_d, src_d, tmp_d;
    logic        temp_en, volt_en, lim_en, crit_n, alert_n, irq;
    logic [7:0]  awaddr, araddr, straps;
    logic [31:0] wdata, rdata, rd_v;
    logic [1:0]  bresp, rresp, wr_resp, rd_resp;
    logic [10:0] sen_in, src_in, sen_r, src_r, psamp;
    logic [15:0] power;
    int          fail_count, total_checks;
    // Rows: sense, source, expected power ratio, expected enables per mode
    logic [10:0] t_sen [4] = '{11'h064, 11'h79C, 11'h400, 11'h155};
    logic [10:0] t_src [4] = '{11'h0C8, 11'h0C8, 11'h7FF, 11'h2AA};
    logic [15:0] t_pwr [4] = '{16'h0271, 16'h0271, 16'hFFE0, 16'h1C63};
    logic [2:0]  t_en  [4] = '{3'h7, 3'h3, 3'h5, 3'h0};

    ppm_core #(.TICK_CYC(10), .FILTER_CYC(3)) u_ppm_core (
        .CLK(clk), .RESET(rst), .CE(ce),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SENSE_RESULT(sen_r), .SENSE_DONE(sen_d), .SOURCE_RESULT(src_r), .SOURCE_DONE(src_d),
        .TEMP_DONE(tmp_d), .PEAK_SAMPLE(psamp), .THRESHOLD_SELECT_PIN(straps[3:0]),
        .DURATION_SELECT_PIN(straps[7:4]),
        .TEMP_CONV_EN(temp_en), .VOLT_CONV_EN(volt_en), .LIMIT_CHK_EN(lim_en),
        .POWER_RATIO(power), .CRITICAL_ALARM_PIN_N(crit_n), .ALERT_PIN_N(alert_n), .IRQ(irq)
    );
    ppm_conv_model u_ppm_conv_model (
        .clk(clk), .rst(rst), .temp_en(temp_en), .volt_en(volt_en), .go(go), .sense_in(sen_in),
        .source_in(src_in), .sense_out(sen_r), .sense_done(sen_d), .source_out(src_r),
        .source_done(src_d), .temp_done(tmp_d)
    );
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task look;
        @(negedge clk);
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do @(posedge clk); while (awready !== 1'b1);
        {awvalid, wvalid} <= 2'h0;
        do @(posedge clk); while (bvalid !== 1'b1);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        {rd_resp, rd_v} = {rresp, rdata};
        rready <= 1'b0;
    endtask
    // Results are offered to the converter with a one-cycle go; they are lost if its enables are off
    task conv(input logic [10:0] s, input logic [10:0] v);
        @(posedge clk);
        {sen_in, src_in, go} <= {s, v, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        cyc(6);
        look;
    endtask
    // Threshold select 0, duration select 1: a 5 ms peak with a short dropout
    task peak(input logic cmp);
        psamp <= 11'h07F;
        cyc(70);
        look;
        chk(crit_n, 1'b1);
        @(posedge clk);
        psamp <= 11'h738;
        cyc(40);
        look;
        chk(crit_n, 1'b1);
        @(posedge clk);
        psamp <= 11'h000;
        cyc(2);
        psamp <= 11'h738;
        cyc(18);
        look;
        chk({crit_n, alert_n}, {1'b0, ~cmp});
        rd(`PPM_OFS_STATUS);
        chk(rd_v[2:0], 3'h3);
        @(posedge clk);
        psamp <= 11'h000;
        cyc(3);
        look;
        chk(crit_n, 1'b0);
        cyc(5);
        look;
        chk({crit_n, alert_n}, 2'h3);
        rd(`PPM_OFS_STATUS);
        chk(rd_v[2:0], 3'h2);
    endtask
    task end_of_test;
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test;
    end
    initial begin
        {rst, go, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        {ce, straps} = 9'h1FF;
        {awaddr, araddr, wdata} = 48'h0;
        {sen_in, src_in, psamp} = 33'h0;
        {fail_count, total_checks} = 64'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        look;
        chk({crit_n, alert_n, irq, power}, 19'h6_0000);
        rd(`PPM_OFS_PEAKCFG);
        chk(rd_v[7:0], 8'hFF);
        rd(`PPM_OFS_IRQ_MASK);
        chk(rd_v, 32'h0000_0007);
        rd(8'h40);
        chk({rd_resp, rd_v}, 34'h2_0000_0000);
        wr(8'h40, 32'h0000_0001);
        chk(wr_resp, 2'h2);
        for (int i = 0; i < 4; i++) begin
            conv(t_sen[i], t_src[i]);
            chk(power, t_pwr[i]);
            rd(`PPM_OFS_RESULTS);
            chk(rd_v, {5'h00, t_src[i], 5'h00, t_sen[i]});
        end
        for (int m = 0; m < 4; m++) begin
            wr(`PPM_OFS_CONFIG, 32'(m));
            cyc(2);
            look;
            chk({temp_en, volt_en, lim_en}, t_en[m]);
        end
        conv(t_sen[0], t_src[0]);
        chk(power, t_pwr[3]);
        rd(`PPM_OFS_CONFIG);
        chk(rd_v[1:0], `PPM_MODE_STANDBY);
        wr(`PPM_OFS_ONESHOT, 32'h0000_0001);
        cyc(2);
        look;
        chk({temp_en, volt_en, lim_en}, 3'h7);
        conv(t_sen[0], t_src[0]);
        cyc(10);
        look;
        chk({temp_en, volt_en, lim_en, power}, {3'h0, t_pwr[0]});
        wr(`PPM_OFS_CONFIG, 32'h0000_0001);
        wr(`PPM_OFS_ONESHOT, 32'h0000_0001);
        cyc(2);
        look;
        chk(temp_en, 1'b1);
        cyc(12);
        look;
        chk({temp_en, volt_en}, 2'h1);
        wr(`PPM_OFS_CONFIG, 32'h0000_0002);
        wr(`PPM_OFS_ONESHOT, 32'h0000_0001);
        cyc(2);
        look;
        chk(volt_en, 1'b1);
        conv(t_sen[2], t_src[2]);
        chk({volt_en, temp_en, power}, {2'h1, t_pwr[2]});
        wr(`PPM_OFS_CONFIG, 32'h0000_0004);
        wr(`PPM_OFS_ONESHOT, 32'h0000_0001);
        rd(`PPM_OFS_ONESHOT);
        chk(rd_v[1:0], 2'h0);
        wr(`PPM_OFS_PEAKCFG, 32'h0000_0010);
        peak(1'b1);
        wr(`PPM_OFS_IRQ_MASK, 32'h0000_0000);
        cyc(2);
        look;
        chk(irq, 1'b0);
        wr(`PPM_OFS_IRQ_MASK, 32'h0000_0007);
        cyc(2);
        look;
        chk(irq, 1'b1);
        rd(`PPM_OFS_IRQ_STAT);
        chk(rd_v[0], 1'b1);
        cyc(2);
        look;
        chk(irq, 1'b0);
        wr(`PPM_OFS_CONFIG, 32'h0000_0000);
        peak(1'b0);
        // Enable low: a peak long enough to trip must leave the timer frozen
        @(posedge clk);
        {ce, psamp} <= {1'b0, 11'h738};
        cyc(70);
        look;
        chk(crit_n, 1'b1);
        @(posedge clk);
        {ce, psamp} <= {1'b1, 11'h000};
        cyc(3);
        look;
        chk(crit_n, 1'b1);
        // Second reset in mid-run: straps are caught again
        @(posedge clk);
        {rst, straps} <= {1'b1, 8'h21};
        cyc(2);
        rst <= 1'b0;
        look;
        chk({crit_n, alert_n, irq, power}, 19'h6_0000);
        rd(`PPM_OFS_PEAKCFG);
        chk(rd_v[7:0], 8'h21);
        end_of_test;
    end
endmodule // power_peak_monitor_core_bench
`default_nettype wire
